/* File: latc_pkg.sv */
package latc_pkg;
   localparam int DATA_W = 16;
   localparam int NUM_PROC = 4;
   localparam int NUM_ALARM = 6;
   localparam int T_DEBOUNCE_US = 10000;
   localparam int CLK_MHZ = 25;
   localparam int DEBOUNCE_CYC = T_DEBOUNCE_US * CLK_MHZ;
   localparam int T_SAVE_HOLD_MS = 2000;
   localparam int SAVE_HOLD_CYC = T_SAVE_HOLD_MS * 1000 * CLK_MHZ;
   localparam logic [15:0] OFFSET_RST = 16'h0000;
   localparam logic [15:0] TARE_RST = 16'h0000;
   localparam logic [15:0] LIMIT_RST = 16'h03E8;
   localparam logic [5:0] NC_RST = 6'h00;
   typedef enum logic [3:0] {
      LATC_SHOW_PV,
      LATC_SHOW_RATE,
      LATC_SHOW_LIM1,
      LATC_SHOW_LIM2,
      LATC_SHOW_LIM3,
      LATC_SHOW_LIM4,
      LATC_SHOW_TMR1,
      LATC_SHOW_TMR2,
      LATC_SHOW_TIME
   } latc_view_t;
   typedef enum logic [3:0] {
      LATC_MSG_NONE,
      LATC_MSG_PROC_LABEL,
      LATC_MSG_RATE_LABEL,
      LATC_MSG_DEV_LABEL,
      LATC_MSG_TMR1_LABEL,
      LATC_MSG_TMR2_LABEL,
      LATC_MSG_RLY_CLR,
      LATC_MSG_COMMIT,
      LATC_MSG_REMOTE_TARE_SELECT_MSG,
      LATC_MSG_REMOTE_HOLD_SELECT_MSG,
      LATC_MSG_TIME_CLR
   } latc_msg_t;
endpackage

/* File: latc_debounce.sv */
`timescale 1ns/100ps
// Three-stage synchroniser then a stability counter
module latc_debounce #(
   parameter int WIDTH = 1,
   parameter int STABLE_CYC = 250000
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Raw contacts and clean levels
   input wire logic [WIDTH-1:0] raw_in,
   output logic [WIDTH-1:0] clean_out
);
   localparam int CW = $clog2(STABLE_CYC + 1);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : gen_bit
         logic s1_q, s2_q, s3_q;
         logic [CW-1:0] cnt_q;
         logic lvl_q;
         always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end else begin
               s1_q <= raw_in[g];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         // A change counts only when the last two stages agree and persist
         always_ff @(posedge clk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               cnt_q <= '0;
               lvl_q <= 1'b0;
            end else if (s2_q != s3_q || s3_q == lvl_q) begin
               cnt_q <= '0;
            end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
               cnt_q <= '0;
               lvl_q <= s3_q;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
         assign clean_out[g] = lvl_q;
      end
   endgenerate
endmodule

/* File: latc_alarm.sv */
`timescale 1ns/100ps
// One alarm channel: compare, latch, polarity
module latc_alarm #(
   parameter int DW = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Compare inputs
   input wire logic [DW-1:0] value_in,
   input wire logic [DW-1:0] limit_in,
   // Configuration
   input wire logic latch_in,
   input wire logic nc_in,
   input wire logic clear_in,
   // Results
   output logic active_out,
   output logic drive_out,
   output logic led_out
);
   logic act_q;
   logic reached;
   assign reached = $signed(value_in) >= $signed(limit_in);
   // A reached limit beats a simultaneous clear
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         act_q <= 1'b0;
      end else if (reached) begin
         act_q <= 1'b1;
      end else if (!latch_in) begin
         act_q <= 1'b0;
      end else if (clear_in) begin
         act_q <= 1'b0;
      end
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         drive_out <= 1'b0;
         led_out <= 1'b0;
      end else begin
         drive_out <= act_q ^ nc_in;
         led_out <= act_q;
      end
   end
   assign active_out = act_q;
endmodule

/* File: latc_top.sv */
`timescale 1ns/100ps
// Summary of operation
// - Offset is subtracted from the input so a chosen level reads zero.
// - Offset may be viewed or changed only in setup mode.
// - Stored tare is subtracted from the reading before display.
// - Tare key during tare entry in setup captures the live reading.
// - Remote tare captures the reading every update while contact active.
// - Setup option picks remote tare or hold; the choice is shown.
// - Hold mode freezes the displayed value while the contact is active.
// - Limits key steps rate, limits one to four, then timers one, two.
// - Limits key during elapsed time shows timer one, then timer two.
// - Each alarm activates when its limit is reached.
// - Non-latching alarms clear themselves once below the limit.
// - Latching alarms stay active until explicitly cleared.
// - Limits held plus reset clears the shown alarm, shows a message.
// - Time plus reset zeroes time and clears both timer alarms.
// - Each output is normally open or closed, open by default.
// - Each alarm lights its indicator while active.
// - Offset and tare are committed only after reset is held SAVE_HOLD_CYC cycles in setup.
// - Unsaved changes are lost; saved values return at power-up.
module latc_top #(
   parameter int DW = latc_pkg::DATA_W,
   parameter int DEBOUNCE_CYC = latc_pkg::DEBOUNCE_CYC,
   parameter int SAVE_HOLD_CYC = latc_pkg::SAVE_HOLD_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Front panel keys and remote contact (raw, asynchronous)
   input wire logic key_limits_in,
   input wire logic key_reset_in,
   input wire logic key_time_in,
   input wire logic key_tare_in,
   input wire logic remote_contact_in,
   // Measurement side
   input wire logic [DW-1:0] scaled_in,
   input wire logic sample_strobe_in,
   input wire logic [DW-1:0] rate_in,
   input wire logic [DW-1:0] deviation_in,
   input wire logic [DW-1:0] elapsed_in,
   // Setup editing
   input wire logic setup_mode_in,
   input wire logic tare_entry_in,
   input wire logic offset_wr_in,
   input wire logic [DW-1:0] offset_wdata_in,
   input wire logic tare_wr_in,
   input wire logic [DW-1:0] tare_wdata_in,
   input wire logic limit_wr_in,
   input wire logic [2:0] limit_sel_in,
   input wire logic [DW-1:0] limit_wdata_in,
   input wire logic cfg_wr_in,
   input wire logic [5:0] latch_cfg_in,
   input wire logic [5:0] nc_cfg_in,
   input wire logic lim3_rate_in,
   input wire logic lim4_dev_in,
   input wire logic remote_hold_in,
   // Nonvolatile store
   input wire logic nv_valid_in,
   input wire logic [DW-1:0] nv_offset_in,
   input wire logic [DW-1:0] nv_tare_in,
   output logic nv_commit_out,
   output logic [DW-1:0] nv_offset_out,
   output logic [DW-1:0] nv_tare_out,
   // Display
   output logic [DW-1:0] disp_value_out,
   output latc_pkg::latc_view_t view_out,
   output latc_pkg::latc_msg_t msg_out,
   output logic [DW-1:0] offset_view_out,
   output logic elapsed_clear_out,
   // Alarms
   output logic [5:0] alarm_drive_out,
   output logic [5:0] alarm_led_out
);
   logic rs1_q, rs2_q;
   logic rst_b;
   logic [4:0] keys;
   logic k_lim, k_rst, k_time, k_tare, k_rem;
   logic k_lim_q, k_rst_q, k_time_q, k_tare_q;
   logic lim_press, rst_press, tare_press;
   logic [DW-1:0] offset_q, tare_q, saved_offset_q, saved_tare_q;
   logic [DW-1:0] net_live, disp_q;
   logic [DW-1:0] limit_q [latc_pkg::NUM_ALARM];
   logic [5:0] latch_q, nc_q;
   logic lim3_rate_q, lim4_dev_q, rem_hold_q;
   logic loaded_q;
   latc_pkg::latc_view_t view_q;
   latc_pkg::latc_msg_t msg_q;
   logic [5:0] clr;
   logic [DW-1:0] cmp_val [latc_pkg::NUM_ALARM];
   localparam int SCW = $clog2(SAVE_HOLD_CYC + 1);
   logic [SCW-1:0] save_cnt_q;
   logic saved_q;

   // Release reset through two flops
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end
   assign rst_b = rs2_q;

   latc_debounce #(
      .WIDTH(5),
      .STABLE_CYC(DEBOUNCE_CYC)
   ) u_deb (
      .clk_in(clk_in),
      .rst_b_in(rst_b),
      .raw_in({remote_contact_in, key_tare_in, key_time_in, key_reset_in,
               key_limits_in}),
      .clean_out(keys)
   );
   assign k_lim = keys[0];
   assign k_rst = keys[1];
   assign k_time = keys[2];
   assign k_tare = keys[3];
   assign k_rem = keys[4];

   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         k_lim_q <= 1'b0;
         k_rst_q <= 1'b0;
         k_time_q <= 1'b0;
         k_tare_q <= 1'b0;
      end else begin
         k_lim_q <= k_lim;
         k_rst_q <= k_rst;
         k_time_q <= k_time;
         k_tare_q <= k_tare;
      end
   end
   assign lim_press = k_lim && !k_lim_q;
   assign rst_press = k_rst && !k_rst_q;
   assign tare_press = k_tare && !k_tare_q;

   // Working offset and tare; saved copies are what survive power loss
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         offset_q <= latc_pkg::OFFSET_RST;
         tare_q <= latc_pkg::TARE_RST;
         loaded_q <= 1'b0;
      end else if (!loaded_q) begin
         loaded_q <= 1'b1;
         if (nv_valid_in) begin
            offset_q <= nv_offset_in;
            tare_q <= nv_tare_in;
         end
      end else begin
         if (setup_mode_in && offset_wr_in) begin
            offset_q <= offset_wdata_in;
         end
         if (!rem_hold_q && k_rem && sample_strobe_in) begin
            tare_q <= scaled_in - offset_q;
         end else if (setup_mode_in && tare_entry_in && tare_press) begin
            tare_q <= scaled_in - offset_q;
         end else if (setup_mode_in && tare_wr_in) begin
            tare_q <= tare_wdata_in;
         end
      end
   end
   assign offset_view_out = setup_mode_in ? offset_q : '0;

   // Configuration written in setup
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < latc_pkg::NUM_ALARM; i++) begin
            limit_q[i] <= latc_pkg::LIMIT_RST;
         end
         latch_q <= 6'h00;
         nc_q <= latc_pkg::NC_RST;
         lim3_rate_q <= 1'b0;
         lim4_dev_q <= 1'b0;
         rem_hold_q <= 1'b0;
      end else if (setup_mode_in) begin
         if (limit_wr_in && limit_sel_in < 3'h6) begin
            limit_q[limit_sel_in] <= limit_wdata_in;
         end
         if (cfg_wr_in) begin
            latch_q <= latch_cfg_in;
            nc_q <= nc_cfg_in;
            lim3_rate_q <= lim3_rate_in;
            lim4_dev_q <= lim4_dev_in;
            rem_hold_q <= remote_hold_in;
         end
      end
   end

   assign net_live = scaled_in - offset_q - tare_q;

   // Display value freezes while remote hold is active
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         disp_q <= '0;
      end else if (!(rem_hold_q && k_rem)) begin
         disp_q <= net_live;
      end
   end
   assign disp_value_out = disp_q;

   // Limits view sequencing
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         view_q <= latc_pkg::LATC_SHOW_PV;
      end else if (k_time && !k_time_q) begin
         view_q <= latc_pkg::LATC_SHOW_TIME;
      end else if (lim_press) begin
         case (view_q)
            latc_pkg::LATC_SHOW_TIME:
               view_q <= latc_pkg::LATC_SHOW_TMR1;
            latc_pkg::LATC_SHOW_RATE:
               view_q <= latc_pkg::LATC_SHOW_LIM1;
            latc_pkg::LATC_SHOW_LIM1: view_q <= latc_pkg::LATC_SHOW_LIM2;
            latc_pkg::LATC_SHOW_LIM2: view_q <= latc_pkg::LATC_SHOW_LIM3;
            latc_pkg::LATC_SHOW_LIM3: view_q <= latc_pkg::LATC_SHOW_LIM4;
            latc_pkg::LATC_SHOW_LIM4:
               view_q <= latc_pkg::LATC_SHOW_TMR1;
            latc_pkg::LATC_SHOW_TMR1:
               view_q <= latc_pkg::LATC_SHOW_TMR2;
            default: view_q <= latc_pkg::LATC_SHOW_RATE;
         endcase
      end
   end
   assign view_out = view_q;

   // Clear strobes: limits held plus reset clears the shown alarm
   always_comb begin
      clr = 6'h00;
      if (rst_press && k_lim) begin
         case (view_q)
            latc_pkg::LATC_SHOW_LIM1: clr[0] = 1'b1;
            latc_pkg::LATC_SHOW_LIM2: clr[1] = 1'b1;
            latc_pkg::LATC_SHOW_LIM3: clr[2] = 1'b1;
            latc_pkg::LATC_SHOW_LIM4: clr[3] = 1'b1;
            latc_pkg::LATC_SHOW_TMR1: clr[4] = 1'b1;
            latc_pkg::LATC_SHOW_TMR2: clr[5] = 1'b1;
            default: clr = 6'h00;
         endcase
      end
      if (rst_press && k_time) begin
         clr[5:4] = 2'b11;
      end
   end
   assign elapsed_clear_out = rst_press && k_time;

   // Messages shown beside the value
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         msg_q <= latc_pkg::LATC_MSG_NONE;
      end else if (saved_q) begin
         msg_q <= latc_pkg::LATC_MSG_COMMIT;
      end else if (rst_press && k_time) begin
         msg_q <= latc_pkg::LATC_MSG_TIME_CLR;
      end else if (|clr) begin
         msg_q <= latc_pkg::LATC_MSG_RLY_CLR;
      end else if (setup_mode_in) begin
         msg_q <= rem_hold_q ? latc_pkg::LATC_MSG_REMOTE_HOLD_SELECT_MSG
                             : latc_pkg::LATC_MSG_REMOTE_TARE_SELECT_MSG;
      end else if (lim_press) begin
         case (view_q)
            latc_pkg::LATC_SHOW_LIM2: msg_q <= lim3_rate_q ?
               latc_pkg::LATC_MSG_RATE_LABEL : latc_pkg::LATC_MSG_PROC_LABEL;
            latc_pkg::LATC_SHOW_LIM3: msg_q <= lim4_dev_q ?
               latc_pkg::LATC_MSG_DEV_LABEL : latc_pkg::LATC_MSG_PROC_LABEL;
            latc_pkg::LATC_SHOW_LIM4, latc_pkg::LATC_SHOW_TIME:
               msg_q <= latc_pkg::LATC_MSG_TMR1_LABEL;
            latc_pkg::LATC_SHOW_TMR1: msg_q <= latc_pkg::LATC_MSG_TMR2_LABEL;
            latc_pkg::LATC_SHOW_RATE, latc_pkg::LATC_SHOW_LIM1:
               msg_q <= latc_pkg::LATC_MSG_PROC_LABEL;
            default: msg_q <= latc_pkg::LATC_MSG_RATE_LABEL;
         endcase
      end
   end
   assign msg_out = msg_q;

   // Commit after reset held long enough in setup; one pulse per hold
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         save_cnt_q <= '0;
         saved_q <= 1'b0;
         nv_commit_out <= 1'b0;
         saved_offset_q <= latc_pkg::OFFSET_RST;
         saved_tare_q <= latc_pkg::TARE_RST;
      end else begin
         nv_commit_out <= 1'b0;
         saved_q <= 1'b0;
         if (!loaded_q && nv_valid_in) begin
            saved_offset_q <= nv_offset_in;
            saved_tare_q <= nv_tare_in;
         end
         if (!(setup_mode_in && k_rst && !k_lim && !k_time)) begin
            save_cnt_q <= '0;
         end else if (save_cnt_q == SCW'(SAVE_HOLD_CYC - 1)) begin
            save_cnt_q <= save_cnt_q + 1'b1;
            saved_q <= 1'b1;
            nv_commit_out <= 1'b1;
            saved_offset_q <= offset_q;
            saved_tare_q <= tare_q;
         end else if (save_cnt_q < SCW'(SAVE_HOLD_CYC)) begin
            save_cnt_q <= save_cnt_q + 1'b1;
         end
      end
   end
   assign nv_offset_out = saved_offset_q;
   assign nv_tare_out = saved_tare_q;

   // Compare sources: limit three may watch rate, four deviation
   always_comb begin
      cmp_val[0] = disp_q;
      cmp_val[1] = disp_q;
      cmp_val[2] = lim3_rate_q ? rate_in : disp_q;
      cmp_val[3] = lim4_dev_q ? deviation_in : disp_q;
      cmp_val[4] = elapsed_in;
      cmp_val[5] = elapsed_in;
   end

   genvar a;
   generate
      for (a = 0; a < latc_pkg::NUM_ALARM; a++) begin : gen_alarm
         latc_alarm #(
            .DW(DW)
         ) u_alarm (
            .clk_in(clk_in),
            .rst_b_in(rst_b),
            .value_in(cmp_val[a]),
            .limit_in(limit_q[a]),
            .latch_in(latch_q[a]),
            .nc_in(nc_q[a]),
            .clear_in(clr[a]),
            .active_out(),
            .drive_out(alarm_drive_out[a]),
            .led_out(alarm_led_out[a])
         );
      end
   endgenerate
endmodule

/* File: latc_panel.sv */
`timescale 1ns/100ps
// Keypad and remote contact: each change chatters before settling
module latc_panel (
   // Clock
   input wire logic clk_in,
   // Requested levels, bit 0 limits, 1 reset, 2 time, 3 tare, 4 remote
   input wire logic [4:0] want_in,
   // Contact levels
   output logic [4:0] pins_out = 5'h00
);
   logic [4:0] last_q = 5'h00;
   logic [4:0] diff_q = 5'h00;
   logic [1:0] chat_q = 2'h0;
   // Only the keys that moved chatter, so no false press on the others
   always @(negedge clk_in) begin
      if (want_in != last_q) begin
         last_q <= want_in;
         diff_q <= want_in ^ last_q;
         chat_q <= 2'h3;
      end else if (chat_q != 2'h0) begin
         chat_q <= chat_q - 2'h1;
      end
      pins_out <= last_q ^ (chat_q[0] ? diff_q : 5'h00);
   end
endmodule

/* File: latc_top_asserts.sv */
`timescale 1ns/100ps
module latc_chk (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Inputs seen at the pins
   input wire logic key_reset_in,
   input wire logic key_limits_in,
   input wire logic key_time_in,
   input wire logic remote_contact_in,
   input wire logic setup_mode_in,
   input wire logic cfg_wr_in,
   input wire logic [5:0] nc_cfg_in,
   input wire logic remote_hold_in,
   // Results
   input wire logic nv_commit_out,
   input wire logic [15:0] nv_offset_out,
   input wire logic [15:0] nv_tare_out,
   input wire logic [15:0] disp_value_out,
   input wire latc_pkg::latc_view_t view_out,
   input wire latc_pkg::latc_msg_t msg_out,
   input wire logic [15:0] offset_view_out,
   input wire logic elapsed_clear_out,
   input wire logic [5:0] alarm_drive_out,
   input wire logic [5:0] alarm_led_out
);
   logic [5:0] nc_q;
   logic hold_q;
   logic [2:0] up_q;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // Mirror of the configuration captured by a setup write
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         nc_q <= 6'h00;
         hold_q <= 1'b0;
      end else if (cfg_wr_in && setup_mode_in) begin
         nc_q <= nc_cfg_in;
         hold_q <= remote_hold_in;
      end
   end
   // Masks the power-up load of the saved copy
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in)
         up_q <= 3'h0;
      else if (up_q != 3'h7)
         up_q <= up_q + 3'h1;
   end
   property p_offset_hidden;
      !setup_mode_in |-> offset_view_out == 16'h0000;
   endproperty
   a_offset_hidden: assert property (p_offset_hidden)
      else $error("offset visible outside setup");
   property p_polarity;
      !cfg_wr_in && !$past(cfg_wr_in) && !$past(cfg_wr_in, 2)
         |-> alarm_drive_out == (alarm_led_out ^ nc_q);
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("alarm output level wrong");
   property p_commit_pulse;
      nv_commit_out |-> $past(setup_mode_in) && $past(key_reset_in, 8)
         ##1 !nv_commit_out;
   endproperty
   a_commit_pulse: assert property (p_commit_pulse)
      else $error("commit without held reset key in setup");
   property p_commit_msg;
      nv_commit_out |-> ##[0:1] msg_out == latc_pkg::LATC_MSG_COMMIT;
   endproperty
   a_commit_msg: assert property (p_commit_msg)
      else $error("commit message missing");
   property p_saved_stable;
      up_q == 3'h7 && ($changed(nv_offset_out) || $changed(nv_tare_out))
         |-> nv_commit_out || $past(nv_commit_out);
   endproperty
   a_saved_stable: assert property (p_saved_stable)
      else $error("saved copy changed without commit");
   property p_view_cause;
      up_q == 3'h7 && $changed(view_out)
         |-> $past(key_limits_in, 3) || $past(key_time_in, 3);
   endproperty
   a_view_cause: assert property (p_view_cause)
      else $error("view moved without a key");
   property p_tmr1_label;
      $changed(view_out) && view_out == latc_pkg::LATC_SHOW_TMR1
         |-> ##[0:1] msg_out == latc_pkg::LATC_MSG_TMR1_LABEL;
   endproperty
   a_tmr1_label: assert property (p_tmr1_label)
      else $error("timer one label missing");
   property p_hold;
      (hold_q && remote_contact_in)[*8] ##1 (hold_q && remote_contact_in)[*4]
         |=> $stable(disp_value_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("display moved during hold");
   property p_time_clear;
      elapsed_clear_out |-> $past(key_time_in, 5) && $past(key_reset_in, 5)
         ##1 !elapsed_clear_out;
   endproperty
   a_time_clear: assert property (p_time_clear)
      else $error("time cleared without time and reset keys");
endmodule
bind latc_top latc_chk chk_u (.clk_in, .rst_b_in, .key_reset_in,
   .key_limits_in, .key_time_in, .remote_contact_in, .setup_mode_in,
   .cfg_wr_in, .nc_cfg_in, .remote_hold_in, .nv_commit_out, .nv_offset_out,
   .nv_tare_out, .disp_value_out, .view_out, .msg_out, .offset_view_out,
   .elapsed_clear_out, .alarm_drive_out, .alarm_led_out);

/* File: latc_top_bench.sv */
`timescale 1ns/100ps
module latc_top_bench;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [4:0] want = 5'h00;
   logic key_limits_in, key_reset_in, key_time_in, key_tare_in;
   logic remote_contact_in;
   logic [15:0] scaled_in = 16'h0000, rate_in = 16'h0000;
   logic [15:0] deviation_in = 16'h0000, elapsed_in = 16'h0000;
   logic [15:0] offset_wdata_in = 16'h0000, tare_wdata_in = 16'h0000;
   logic [15:0] limit_wdata_in = 16'h0000, nv_offset_in = 16'h0000;
   logic [15:0] nv_tare_in = 16'h0000;
   logic sample_strobe_in = 1'b0, setup_mode_in = 1'b0;
   logic tare_entry_in = 1'b0, offset_wr_in = 1'b0, tare_wr_in = 1'b0;
   logic limit_wr_in = 1'b0, cfg_wr_in = 1'b0, lim3_rate_in = 1'b0;
   logic lim4_dev_in = 1'b0, remote_hold_in = 1'b0, nv_valid_in = 1'b0;
   logic [2:0] limit_sel_in = 3'h0;
   logic [5:0] latch_cfg_in = 6'h00, nc_cfg_in = 6'h00;
   logic nv_commit_out, elapsed_clear_out;
   logic [15:0] nv_offset_out, nv_tare_out, disp_value_out, offset_view_out;
   latc_pkg::latc_view_t view_out;
   latc_pkg::latc_msg_t msg_out;
   logic [5:0] alarm_drive_out, alarm_led_out;
   logic [15:0] lim [6] = '{16'h0064, 16'h0064, 16'h03E8, 16'h03E8,
      16'h0032, 16'h0032};
   logic [15:0] off, tar, r, v;
   int error_cnt = 0, check_count = 0, clr_n = 0;
   always #20 clk_in = ~clk_in;
   // The time-clear strobe is combinational and stands one cycle
   always @(negedge clk_in)
      if (elapsed_clear_out) clr_n++;
   latc_panel pnl_u (.clk_in, .want_in(want), .pins_out({remote_contact_in,
      key_tare_in, key_time_in, key_reset_in, key_limits_in}));
   // Short counts keep key holds to a few cycles
   latc_top #(.DEBOUNCE_CYC(4), .SAVE_HOLD_CYC(8)) dut_u (.clk_in,
      .rst_b_in, .key_limits_in, .key_reset_in, .key_time_in, .key_tare_in,
      .remote_contact_in, .scaled_in, .sample_strobe_in, .rate_in,
      .deviation_in, .elapsed_in, .setup_mode_in, .tare_entry_in,
      .offset_wr_in, .offset_wdata_in, .tare_wr_in, .tare_wdata_in,
      .limit_wr_in, .limit_sel_in, .limit_wdata_in, .cfg_wr_in, .latch_cfg_in,
      .nc_cfg_in, .lim3_rate_in, .lim4_dev_in, .remote_hold_in, .nv_valid_in,
      .nv_offset_in, .nv_tare_in, .nv_commit_out, .nv_offset_out,
      .nv_tare_out, .disp_value_out, .view_out, .msg_out, .offset_view_out,
      .elapsed_clear_out, .alarm_drive_out, .alarm_led_out);
   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // Waits past chatter, sync and debounce before anyone looks
   task automatic key(input logic [4:0] m, input logic on);
      want <= on ? (want | m) : (want & ~m);
      cyc(16);
   endtask
   task automatic press(input logic [4:0] m);
      key(m, 1'b1);
      key(m, 1'b0);
   endtask
   task automatic wr(input logic [1:0] k, logic [2:0] s, logic [15:0] d);
      offset_wr_in <= k == 2'h0;
      tare_wr_in <= k == 2'h1;
      limit_wr_in <= k == 2'h2;
      cfg_wr_in <= k == 2'h3;
      {offset_wdata_in, tare_wdata_in, limit_wdata_in} <= {3{d}};
      limit_sel_in <= s;
      cyc(1);
      {offset_wr_in, tare_wr_in, limit_wr_in, cfg_wr_in} <= 4'h0;
      cyc(1);
   endtask
   // Two strobes, so a capture and the display both see the new value
   task automatic set_pv(input logic [15:0] x);
      scaled_in <= x;
      repeat (2) begin
         sample_strobe_in <= 1'b1;
         cyc(1);
         sample_strobe_in <= 1'b0;
         cyc(1);
      end
      cyc(4);
   endtask
   initial begin
      void'($urandom(32'hce725315));
      cyc(5);
      rst_b_in <= 1'b1;
      cyc(6);
      setup_mode_in <= 1'b1;
      latch_cfg_in <= 6'h32;
      nc_cfg_in <= 6'h02;
      {lim3_rate_in, lim4_dev_in} <= 2'h3;
      wr(2'h3, 3'h0, 16'h0000);
      cyc(2);
      chk("msg", latc_pkg::LATC_MSG_REMOTE_TARE_SELECT_MSG, msg_out);
      for (int i = 0; i < 6; i++) wr(2'h2, 3'(i), lim[i]);
      r = 16'($urandom_range(100, 900));
      set_pv(r);
      tare_entry_in <= 1'b1;
      press(5'h08);
      tare_entry_in <= 1'b0;
      set_pv(r + 16'h0007);
      chk("disp", 16'h0007, disp_value_out);
      key(5'h10, 1'b1);
      repeat (2) begin
         r = 16'($urandom_range(100, 900));
         set_pv(r);
         chk("disp", 16'h0000, disp_value_out);
      end
      key(5'h10, 1'b0);
      set_pv(r + 16'h0005);
      chk("disp", 16'h0005, disp_value_out);
      remote_hold_in <= 1'b1;
      wr(2'h3, 3'h0, 16'h0000);
      cyc(2);
      chk("msg", latc_pkg::LATC_MSG_REMOTE_HOLD_SELECT_MSG, msg_out);
      key(5'h10, 1'b1);
      set_pv(r + 16'h0030);
      chk("disp", 16'h0005, disp_value_out);
      key(5'h10, 1'b0);
      set_pv(r + 16'h0030);
      chk("disp", 16'h0030, disp_value_out);
      off = 16'($urandom_range(1, 20));
      tar = 16'($urandom_range(1, 20));
      wr(2'h0, 3'h0, off);
      wr(2'h1, 3'h0, tar);
      chk("offset_view", off, offset_view_out);
      setup_mode_in <= 1'b0;
      wr(2'h0, 3'h0, 16'h0777);
      chk("offset_view", 16'h0000, offset_view_out);
      for (int i = 0; i < 4; i++) begin
         v = off + tar + 16'(i < 3 ? $urandom_range(100, 600)
            : $urandom_range(0, 99));
         set_pv(v);
         chk("disp", v - off - tar, disp_value_out);
         chk("led", i < 3 ? 16'h03 : 16'h02, alarm_led_out);
         chk("drive", i < 3 ? 16'h01 : 16'h00, alarm_drive_out);
      end
      for (int i = 0; i < 7; i++) begin
         key(5'h01, 1'b1);
         chk("view", 16'(latc_pkg::LATC_SHOW_RATE) + 16'(i), view_out);
         if (i > 0)
            chk("msg", 16'(latc_pkg::LATC_MSG_PROC_LABEL)
               + 16'(i < 3 ? 0 : i - 2), msg_out);
         if (i == 2) begin
            key(5'h02, 1'b1);
            chk("led", 16'h00, alarm_led_out);
            chk("drive", 16'h02, alarm_drive_out);
            chk("msg", latc_pkg::LATC_MSG_RLY_CLR, msg_out);
            key(5'h02, 1'b0);
         end
         key(5'h01, 1'b0);
      end
      elapsed_in <= 16'h003C;
      {rate_in, deviation_in} <= {lim[2], lim[3]};
      cyc(5);
      chk("led", 16'h3C, alarm_led_out);
      chk("drive", 16'h3E, alarm_drive_out);
      elapsed_in <= 16'h0000;
      {rate_in, deviation_in} <= 32'h00000000;
      key(5'h04, 1'b1);
      chk("led", 16'h30, alarm_led_out);
      chk("view", latc_pkg::LATC_SHOW_TIME, view_out);
      key(5'h02, 1'b1);
      chk("led", 16'h00, alarm_led_out);
      chk("elapsed_clear", 16'h0001, 16'(clr_n));
      chk("msg", latc_pkg::LATC_MSG_TIME_CLR, msg_out);
      key(5'h06, 1'b0);
      press(5'h01);
      chk("view", latc_pkg::LATC_SHOW_TMR1, view_out);
      press(5'h01);
      chk("view", latc_pkg::LATC_SHOW_TMR2, view_out);
      setup_mode_in <= 1'b1;
      chk("nv_offset", 16'h0000, nv_offset_out);
      want <= want | 5'h02;
      for (int j = 0; j < 100 && nv_commit_out !== 1'b1; j++) cyc(1);
      chk("commit", 16'h0001, 16'(nv_commit_out));
      if (nv_commit_out !== 1'b1)
         wrap_up();
      cyc(2);
      chk("nv_offset", off, nv_offset_out);
      chk("nv_tare", tar, nv_tare_out);
      key(5'h02, 1'b0);
      wr(2'h0, 3'h0, 16'h0055);
      {nv_valid_in, nv_offset_in, nv_tare_in} <= {1'b1, off, tar};
      rst_b_in <= 1'b0;
      cyc(5);
      rst_b_in <= 1'b1;
      cyc(6);
      chk("offset_view", off, offset_view_out);
      chk("nv_tare", tar, nv_tare_out);
      chk("nv_offset", off, nv_offset_out);
      wrap_up();
   end
endmodule
